/* include/cgpm_consts.vh */
/*
  constants of the clock generation and power mode block: timing, states, resets.
  assumes clk_sys at 100 MHz; included by its bare name.
*/
`ifndef CGPM_CONSTS_VH
`define CGPM_CONSTS_VH

// clock period and oscillator watchdog timeout
`define CGPM_CLK_PERIOD_NS  10
`define CGPM_OWD_TIMEOUT_NS 2000
`define CGPM_OWD_CYC        ((`CGPM_OWD_TIMEOUT_NS) / (`CGPM_CLK_PERIOD_NS))

// free-running pll half period in clk_sys cycles
`define CGPM_PLL_BASE_HALF  16'h0004

// power mode states, one-hot
`define CGPM_ST_RUN   4'h1
`define CGPM_ST_IDLE  4'h2
`define CGPM_ST_SLEEP 4'h4
`define CGPM_ST_PDOWN 4'h8

// pin vector layout and reset levels of the pin synchronisers
`define CGPM_PIN_XTAL  0
`define CGPM_PIN_EA    1
`define CGPM_PIN_RD    2
`define CGPM_PIN_NMI   3
`define CGPM_PIN_EIRQ  4
`define CGPM_PIN_NUM   5
`define CGPM_PIN_RST   5'h0E

// strap capture point after reset release
`define CGPM_STRAP_CNT 3'h4

`endif

/* logic/cgpm_clk_mux.v */
/*
  glitch-free selector between two clock levels sampled in clk_sys.
  assumes both inputs are flip-flop outputs of the clk_sys domain.
*/
`timescale 1ns/1ns
module cgpm_clk_mux (
	input  wire clk_sys,
	input  wire arst_n,
	input  wire clk_a,
	input  wire clk_b,
	input  wire sel_b,
	output wire clk_o,
	output wire sel_b_o
);
	reg cur_q;
	reg out_q;
	wire cur_lvl;

	assign cur_lvl = cur_q ? clk_b : clk_a;

	// source swaps only while output and new source are both low
	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			cur_q <= 1'b0;
			out_q <= 1'b0;
		end else if ((cur_q != sel_b) && !out_q && !(sel_b ? clk_b : clk_a)) begin
			cur_q <= sel_b;
			out_q <= 1'b0;
		end else begin
			out_q <= cur_lvl;
		end
	end

	assign clk_o   = out_q;
	assign sel_b_o = cur_q;
endmodule

/* logic/cgpm_clock_power.v */
/*
  clock generation, oscillator watchdog and power mode control.
  assumes clk_sys is fast against the crystal; clocks leave as flip-flop levels.
*/
// Overview of operation
// - cpu and system clocks come from master clock, 1:1 or 2:1, equal except in idle, where the cpu clock stops.
// - master clock is the reference, feeds can clock and goes out.
// - pll multiplies oscillator by factor or prescaler divides it; bypass otherwise.
// - in bypass the pll still runs on its own and monitors the oscillator.
// - missing oscillator edges raise watchdog interrupt and switch to pll clock.
// - emergency pll clock runs at its basic free-running frequency.
// - pll off disables the watchdog; no interrupt then.
// - ea low and read strobe low at reset end disables the watchdog.
// - power modes are entered only by dedicated instructions.
// - idle halts the cpu clock; peripheral clocks keep running.
// - sleep and power down stop all clocks; rtc may keep running.
// - an external interrupt ends sleep mode.
// - inactive logic clocks are gated; software may lower cpu clock.
// - programmable frequency output pin for external circuitry.
// - each peripheral clock is disabled or enabled by its own bit.
// - rtc makes cyclic wake-up signals that end sleep phases.
// - power down takes effect only while the nmi input is low.
`timescale 1ns/1ns
`include "cgpm_consts.vh"
module cgpm_clock_power #(
	parameter NPER = 8,
	parameter OWD_CYC = `CGPM_OWD_CYC
) (
	input  wire            clk_sys,
	input  wire            arst_n,
	input  wire            crystal_in,
	input  wire            ext_access_n,
	input  wire            rd_strobe_n,
	input  wire            nmi_n,
	input  wire            ext_irq,
	input  wire            pll_on,
	input  wire            pll_mode,
	input  wire [3:0]      pll_factor,
	input  wire [3:0]      presc_div,
	input  wire            sys_div2,
	input  wire [NPER-1:0] periph_disable_ctrl,
	input  wire            prog_freq_out_en,
	input  wire [7:0]      prog_freq_out_reload,
	input  wire [15:0]     rtc_reload,
	input  wire            rtc_keep,
	input  wire            rtc_wake_en,
	input  wire            instr_idle,
	input  wire            instr_sleep,
	input  wire            enter_deep_powerdown,
	input  wire            wake_req,
	input  wire            owd_fail_clr,
	output wire            master_clk,
	output wire            can_clk,
	output wire            cpu_clk,
	output wire            system_clk,
	output wire [NPER-1:0] periph_clk,
	output wire            prog_freq_out,
	output wire            rtc_tick,
	output wire            osc_watchdog_irq,
	output wire            osc_fail,
	output wire            osc_watchdog_on,
	output wire            emergency_clk,
	output wire [3:0]      power_mode
);
	// pin synchronisers, three flops each plus an output flop loaded only when two stages agree
	wire [`CGPM_PIN_NUM-1:0] pins;
	reg  [`CGPM_PIN_NUM-1:0] s0_q;
	reg  [`CGPM_PIN_NUM-1:0] s1_q;
	reg  [`CGPM_PIN_NUM-1:0] s2_q;
	reg  [`CGPM_PIN_NUM-1:0] pin_q;
	assign pins = {ext_irq, nmi_n, rd_strobe_n, ext_access_n, crystal_in};
	localparam [`CGPM_PIN_NUM-1:0] PIN_RST = `CGPM_PIN_RST;
	genvar gp;
	generate
		for (gp = 0; gp < `CGPM_PIN_NUM; gp = gp + 1) begin : g_pin
			always @(posedge clk_sys or negedge arst_n) begin
				if (!arst_n) begin
					s0_q[gp]  <= PIN_RST[gp];
					s1_q[gp]  <= PIN_RST[gp];
					s2_q[gp]  <= PIN_RST[gp];
					pin_q[gp] <= PIN_RST[gp];
				end else begin
					s0_q[gp] <= pins[gp];
					s1_q[gp] <= s0_q[gp];
					s2_q[gp] <= s1_q[gp];
					if (s1_q[gp] == s2_q[gp]) begin
						pin_q[gp] <= s2_q[gp];
					end
				end
			end
		end
	endgenerate
	reg [2:0] strap_cnt_q;
	reg       strap_done_q;
	reg       owd_hw_dis_q;
	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			strap_cnt_q  <= 3'h0;
			strap_done_q <= 1'b0;
			owd_hw_dis_q <= 1'b0;
		end else if (!strap_done_q) begin
			if (strap_cnt_q == `CGPM_STRAP_CNT) begin
				strap_done_q <= 1'b1;
				owd_hw_dis_q <= !pin_q[`CGPM_PIN_EA] && !pin_q[`CGPM_PIN_RD];
			end else begin
				strap_cnt_q <= strap_cnt_q + 3'h1;
			end
		end
	end
	reg        osc_prev_q;
	reg [15:0] since_q;
	reg [15:0] period_q;
	reg        fail_q;
	reg        owd_irq_q;
	wire       osc_rise;
	wire       owd_en;
	wire       osc_missing;
	assign osc_rise    = pin_q[`CGPM_PIN_XTAL] && !osc_prev_q;
	assign owd_en      = pll_on && !owd_hw_dis_q && strap_done_q;
	assign osc_missing = (since_q >= OWD_CYC[15:0]);
	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			osc_prev_q <= 1'b0;
			since_q    <= 16'h0000;
			period_q   <= 16'h0000;
			fail_q     <= 1'b0;
			owd_irq_q  <= 1'b0;
		end else begin
			osc_prev_q <= pin_q[`CGPM_PIN_XTAL];
			if (osc_rise) begin
				since_q  <= 16'h0000;
				period_q <= since_q + 16'h0001;
			end else if (since_q != 16'hFFFF) begin
				since_q <= since_q + 16'h0001;
			end
			owd_irq_q <= owd_en && osc_missing && !fail_q;
			if (owd_en && osc_missing) begin
				fail_q <= 1'b1;
			end else if (owd_fail_clr || !owd_en) begin
				fail_q <= 1'b0;
			end
		end
	end
	reg        pll_clk_q;
	reg [15:0] pll_cnt_q;
	reg [15:0] pll_half;
	wire       emerg;
	wire [15:0] pll_quot;
	assign emerg    = fail_q && owd_en;
	assign pll_quot = period_q / {11'h000, pll_factor, 1'b0};
	always @* begin
		if (emerg || pll_factor == 4'h0 || period_q == 16'h0000) begin
			pll_half = `CGPM_PLL_BASE_HALF;
		end else if (pll_quot == 16'h0000) begin
			pll_half = 16'h0001;
		end else begin
			pll_half = pll_quot;
		end
	end
	// pll keeps running in bypass to watch the oscillator
	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			pll_cnt_q <= 16'h0000;
			pll_clk_q <= 1'b0;
		end else if (!pll_on) begin
			pll_cnt_q <= 16'h0000;
			pll_clk_q <= 1'b0;
		end else if (pll_cnt_q >= pll_half - 16'h0001) begin
			pll_cnt_q <= 16'h0000;
			pll_clk_q <= !pll_clk_q;
		end else begin
			pll_cnt_q <= pll_cnt_q + 16'h0001;
		end
	end
	reg [3:0] pre_cnt_q;
	reg       pre_clk_q;
	wire      osc_path;
	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			pre_cnt_q <= 4'h0;
			pre_clk_q <= 1'b0;
		end else if (osc_rise) begin
			if (pre_cnt_q >= presc_div - 4'h1) begin
				pre_cnt_q <= 4'h0;
				pre_clk_q <= !pre_clk_q;
			end else begin
				pre_cnt_q <= pre_cnt_q + 4'h1;
			end
		end
	end
	assign osc_path = (presc_div == 4'h0) ? pin_q[`CGPM_PIN_XTAL] : pre_clk_q;
	// master clock source selection
	wire mc_lvl;
	wire mc_on_pll;
	cgpm_clk_mux u_mux (
		.clk_sys (clk_sys),
		.arst_n  (arst_n),
		.clk_a   (osc_path && !emerg),
		.clk_b   (pll_clk_q),
		.sel_b   ((pll_mode && pll_on) || emerg),
		.clk_o   (mc_lvl),
		.sel_b_o (mc_on_pll)
	);
	// power mode state machine
	reg  [3:0] state_q;
	reg  [3:0] state_d;
	wire       rtc_wake;
	wire       run_all;
	always @* begin
		state_d = state_q;
		case (state_q)
			`CGPM_ST_RUN: begin
				if (enter_deep_powerdown && !pin_q[`CGPM_PIN_NMI]) begin
					state_d = `CGPM_ST_PDOWN;
				end else if (instr_sleep) begin
					state_d = `CGPM_ST_SLEEP;
				end else if (instr_idle) begin
					state_d = `CGPM_ST_IDLE;
				end
			end
			`CGPM_ST_IDLE: begin
				if (wake_req || pin_q[`CGPM_PIN_EIRQ] || rtc_wake) begin
					state_d = `CGPM_ST_RUN;
				end
			end
			`CGPM_ST_SLEEP: begin
				if (pin_q[`CGPM_PIN_EIRQ]) begin
					state_d = `CGPM_ST_RUN;
				end else if (rtc_wake) begin
					state_d = `CGPM_ST_RUN;
				end
			end
			`CGPM_ST_PDOWN: begin
				state_d = `CGPM_ST_PDOWN;
			end
			default: begin
				state_d = `CGPM_ST_RUN;
			end
		endcase
	end
	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			state_q <= `CGPM_ST_RUN;
		end else begin
			state_q <= state_d;
		end
	end
	assign run_all = (state_q == `CGPM_ST_RUN) || (state_q == `CGPM_ST_IDLE);
	// rtc prescaler with cyclic wake-up
	reg [15:0] rtc_cnt_q;
	reg        rtc_tick_q;
	wire       rtc_run;
	assign rtc_run  = run_all || rtc_keep;
	assign rtc_wake = rtc_tick_q && rtc_wake_en;
	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			rtc_cnt_q  <= 16'h0000;
			rtc_tick_q <= 1'b0;
		end else if (!rtc_run) begin
			rtc_tick_q <= 1'b0;
		end else if (rtc_cnt_q >= rtc_reload) begin
			rtc_cnt_q  <= 16'h0000;
			rtc_tick_q <= 1'b1;
		end else begin
			rtc_cnt_q  <= rtc_cnt_q + 16'h0001;
			rtc_tick_q <= 1'b0;
		end
	end
	// derived clock and divide-by-two prescaler
	reg  mc_prev_q;
	reg  div_q;
	wire mc_rise;
	wire core_lvl;
	assign mc_rise  = mc_lvl && !mc_prev_q;
	assign core_lvl = sys_div2 ? div_q : mc_lvl;
	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			mc_prev_q <= 1'b0;
			div_q     <= 1'b0;
		end else begin
			mc_prev_q <= mc_lvl;
			if (mc_rise) begin
				div_q <= !div_q;
			end
		end
	end
	// clock gates; enables change only while the source is low
	reg            cpu_en_q;
	reg            sys_en_q;
	reg            mc_en_q;
	reg [NPER-1:0] per_en_q;
	reg            cpu_clk_q;
	reg            sys_clk_q;
	reg            mc_out_q;
	reg [NPER-1:0] per_clk_q;
	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			cpu_en_q  <= 1'b0;
			sys_en_q  <= 1'b0;
			cpu_clk_q <= 1'b0;
			sys_clk_q <= 1'b0;
		end else begin
			if (!core_lvl) begin
				cpu_en_q <= (state_q == `CGPM_ST_RUN);
				sys_en_q <= run_all;
			end
			cpu_clk_q <= core_lvl && cpu_en_q;
			sys_clk_q <= core_lvl && sys_en_q;
		end
	end
	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			mc_en_q  <= 1'b0;
			mc_out_q <= 1'b0;
		end else begin
			if (!mc_lvl) begin
				mc_en_q <= run_all;
			end
			mc_out_q <= mc_lvl && mc_en_q;
		end
	end
	genvar gi;
	generate
		for (gi = 0; gi < NPER; gi = gi + 1) begin : g_per
			always @(posedge clk_sys or negedge arst_n) begin
				if (!arst_n) begin
					per_en_q[gi]  <= 1'b0;
					per_clk_q[gi] <= 1'b0;
				end else begin
					if (!core_lvl) begin
						per_en_q[gi] <= run_all && !periph_disable_ctrl[gi];
					end
					per_clk_q[gi] <= core_lvl && per_en_q[gi];
				end
			end
		end
	endgenerate
	reg [7:0] prog_freq_out_cnt_q;
	reg       prog_freq_out_q;
	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			prog_freq_out_cnt_q <= 8'h00;
			prog_freq_out_q     <= 1'b0;
		end else if (!prog_freq_out_en || !run_all) begin
			prog_freq_out_cnt_q <= 8'h00;
			prog_freq_out_q     <= 1'b0;
		end else if (mc_rise) begin
			if (prog_freq_out_cnt_q >= prog_freq_out_reload) begin
				prog_freq_out_cnt_q <= 8'h00;
				prog_freq_out_q     <= !prog_freq_out_q;
			end else begin
				prog_freq_out_cnt_q <= prog_freq_out_cnt_q + 8'h01;
			end
		end
	end
	assign master_clk       = mc_out_q;
	assign can_clk          = mc_out_q;
	assign cpu_clk          = cpu_clk_q;
	assign system_clk       = sys_clk_q;
	assign periph_clk       = per_clk_q;
	assign prog_freq_out    = prog_freq_out_q;
	assign rtc_tick         = rtc_tick_q;
	assign osc_watchdog_irq = owd_irq_q;
	assign osc_fail         = fail_q;
	assign osc_watchdog_on  = owd_en;
	assign emergency_clk    = mc_on_pll && emerg;
	assign power_mode       = state_q;
endmodule

/* test/cgpm_clock_power_assertions.sv */
/*
  port checker of the clock and power block.
  assumes a bind onto cgpm_clock_power from the bench.
*/
`timescale 1ns/1ns
module cgpm_clock_power_assertions (
	input wire       clk_sys,
	input wire       arst_n,
	input wire       pll_on,
	input wire       instr_sleep,
	input wire       enter_deep_powerdown,
	input wire       master_clk,
	input wire       can_clk,
	input wire       cpu_clk,
	input wire       system_clk,
	input wire       osc_watchdog_irq,
	input wire       osc_fail,
	input wire       osc_watchdog_on,
	input wire [3:0] power_mode
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!arst_n);
	a_can_master_same: assert property (can_clk == master_clk)
		else $error("can clock differs");
	a_cpu_sys_rise: assert property ($rose(cpu_clk) |-> $rose(system_clk))
		else $error("cpu clock off system clock");
	a_irq_one_pulse: assert property (osc_watchdog_irq |=> !osc_watchdog_irq)
		else $error("irq longer than a cycle");
	a_irq_sets_fail: assert property (osc_watchdog_irq |-> ##[0:1] osc_fail)
		else $error("irq without fail flag");
	a_pll_off_quiet: assert property (
		!$past(pll_on) && !pll_on |-> !osc_watchdog_irq && !osc_watchdog_on)
		else $error("watchdog alive with pll off");
	a_sleep_entry_cause: assert property (
		$rose(power_mode[2]) |-> $past(instr_sleep) && $past(power_mode) == 4'h1)
		else $error("sleep without instruction");
	a_pdown_entry_cause: assert property (
		$rose(power_mode[3]) |-> $past(enter_deep_powerdown))
		else $error("power down without instruction");
	a_pdown_holds: assert property (power_mode[3] |=> power_mode[3])
		else $error("power down left");
	a_sleep_master_low: assert property (
		power_mode == 4'h4 && $past(power_mode) == 4'h4 && $past(power_mode, 2) == 4'h4
		&& !$past(master_clk) |-> !master_clk)
		else $error("master clock runs in sleep");
	a_mode_onehot: assert property ($onehot(power_mode))
		else $error("power mode not one-hot");
endmodule

/* test/cgpm_osc_model.sv */
/*
  crystal oscillator model for the crystal pin.
  assumes the bench stops it to act out a dead crystal.
*/
`timescale 1ns/1ns
module cgpm_osc_model #(
	parameter HALF_NS = 50
) (
	input  wire  osc_run,
	output logic crystal_in
);
	// square wave; a stopped crystal keeps its last level
	initial begin
		crystal_in = 1'b0;
		#3;
		forever begin
			#(HALF_NS);
			if (osc_run) begin
				crystal_in = ~crystal_in;
			end
		end
	end
endmodule

/* test/tb_clock_gen_power_modes.sv */
/*
  self-checking bench of the clock and power block.
  assumes cgpm_osc_model and the port checker bound below.
*/
`timescale 1ns/1ns
`define CHK(g, e, m) begin \
	checks_done++; \
	if ((g) !== (e)) begin \
		failures++; \
		$display("CHECK FAILED at %0t: %s", $time, m); \
	end \
end
module tb_clock_gen_power_modes;
	logic        clk_sys = 1'b0;
	logic        arst_n = 1'b0;
	logic        osc_run = 1'b1;
	logic        ext_access_n = 1'b1;
	logic        rd_strobe_n = 1'b1;
	logic        nmi_n = 1'b1;
	logic        ext_irq = 1'b0;
	logic        pll_on = 1'b1;
	logic        pll_mode = 1'b0;
	logic [3:0]  pll_factor = 4'h0;
	logic [3:0]  presc_div = 4'h0;
	logic        sys_div2 = 1'b0;
	logic [7:0]  periph_disable_ctrl = 8'h00;
	logic [15:0] rtc_reload = 16'h0031;
	logic        rtc_wake_en = 1'b0;
	logic        instr_idle = 1'b0;
	logic        instr_sleep = 1'b0;
	logic        enter_deep_powerdown = 1'b0;
	logic        wake_req = 1'b0;
	logic        owd_fail_clr = 1'b0;
	logic        prog_freq_out_en = 1'b1;
	wire         crystal_in;
	wire         master_clk;
	wire         cpu_clk;
	wire         system_clk;
	wire [7:0]   periph_clk;
	wire         prog_freq_out;
	wire         rtc_tick;
	wire         osc_watchdog_irq;
	wire         osc_fail;
	wire         osc_watchdog_on;
	wire         emergency_clk;
	wire [3:0]   power_mode;
	wire [7:0]   mon = {rtc_tick, emergency_clk, power_mode[0], osc_watchdog_irq,
		prog_freq_out, system_clk, cpu_clk, master_clk};
	int          failures = 0;
	int          checks_done = 0;
	int          irq_seen = 0;

	always #5 clk_sys = ~clk_sys;
	always @(negedge clk_sys) begin
		if (osc_watchdog_irq === 1'b1) begin
			irq_seen++;
		end
	end

	cgpm_osc_model i_osc (.osc_run, .crystal_in);
	cgpm_clock_power #(.NPER(8), .OWD_CYC(20)) i_dut (
		.clk_sys, .arst_n, .crystal_in, .ext_access_n, .rd_strobe_n, .nmi_n, .ext_irq,
		.pll_on, .pll_mode, .pll_factor, .presc_div, .sys_div2, .periph_disable_ctrl,
		.prog_freq_out_en, .prog_freq_out_reload(8'h01), .rtc_reload, .rtc_keep(rtc_wake_en),
		.rtc_wake_en, .instr_idle, .instr_sleep, .enter_deep_powerdown, .wake_req,
		.owd_fail_clr, .master_clk, .can_clk(), .cpu_clk, .system_clk, .periph_clk,
		.prog_freq_out, .rtc_tick, .osc_watchdog_irq, .osc_fail, .osc_watchdog_on,
		.emergency_clk, .power_mode);

	task complete_run;
		$display("failures=%0d checks_done=%0d", failures, checks_done);
		if (failures == 0 && checks_done > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task wait_lvl(input int i, input logic v, output int n);
		n = 0;
		while (mon[i] !== v) begin
			@(negedge clk_sys);
			n++;
			if (n > 4000) begin
				failures++;
				complete_run();
			end
		end
	endtask

	task period(input int i, output int p);
		int a;
		int b;
		wait_lvl(i, 1'b0, a);
		wait_lvl(i, 1'b1, a);
		wait_lvl(i, 1'b0, a);
		wait_lvl(i, 1'b1, b);
		p = a + b;
	endtask

	task pulse(input int k);
		@(posedge clk_sys);
		{enter_deep_powerdown, instr_sleep, instr_idle} <= 3'b001 << k;
		@(posedge clk_sys);
		{enter_deep_powerdown, instr_sleep, instr_idle} <= 3'b000;
	endtask

	task do_reset(input logic ea, input logic rd);
		@(posedge clk_sys);
		arst_n <= 1'b0;
		ext_access_n <= ea;
		rd_strobe_n <= rd;
		repeat (4) @(posedge clk_sys);
		arst_n <= 1'b1;
		repeat (8) @(posedge clk_sys);
		ext_access_n <= 1'b1;
		rd_strobe_n <= 1'b1;
	endtask

	task t_clocks;
		int pm [4] = '{0, 0, 1, 1};
		int pf [4] = '{0, 0, 5, 1};
		int pd [4] = '{0, 2, 0, 0};
		int dv [4] = '{0, 0, 0, 1};
		int ep [4] = '{10, 40, 2, 10};
		int p;
		for (int c = 0; c < 4; c++) begin
			@(posedge clk_sys);
			pll_mode <= pm[c][0];
			pll_factor <= pf[c][3:0];
			presc_div <= pd[c][3:0];
			sys_div2 <= dv[c][0];
			repeat (80) @(posedge clk_sys);
			period(0, p);
			`CHK(p, ep[c], "master period")
			period(2, p);
			`CHK(p, ep[c] << dv[c], "system period")
			period(1, p);
			`CHK(p, ep[c] << dv[c], "cpu period")
			period(3, p);
			`CHK(p, ep[c] * 4, "prog_freq_out period")
		end
		@(posedge clk_sys);
		pll_mode <= 1'b0;
		sys_div2 <= 1'b0;
		repeat (40) @(posedge clk_sys);
	endtask

	task t_periph;
		logic [7:0] acc;
		logic       fo;
		acc = 8'h00;
		fo = 1'b0;
		@(posedge clk_sys);
		periph_disable_ctrl <= 8'h0F;
		prog_freq_out_en <= 1'b0;
		repeat (12) @(negedge clk_sys);
		repeat (40) begin
			@(negedge clk_sys);
			acc |= periph_clk;
			fo |= prog_freq_out;
		end
		`CHK(acc, 8'hF0, "peripheral gating")
		`CHK(fo, 1'b0, "frequency output off")
		@(posedge clk_sys);
		periph_disable_ctrl <= 8'h00;
		prog_freq_out_en <= 1'b1;
	endtask

	task t_idle;
		int n;
		logic hi;
		hi = 1'b0;
		pulse(0);
		wait_lvl(5, 1'b0, n);
		`CHK(power_mode, 4'h2, "idle entry")
		repeat (12) @(negedge clk_sys);
		repeat (40) begin
			@(negedge clk_sys);
			hi |= cpu_clk;
		end
		`CHK(hi, 1'b0, "cpu halted")
		period(2, n);
		`CHK(n, 10, "system runs in idle")
		@(posedge clk_sys);
		wake_req <= 1'b1;
		wait_lvl(5, 1'b1, n);
		`CHK(power_mode, 4'h1, "idle left")
		@(posedge clk_sys);
		wake_req <= 1'b0;
	endtask

	task t_sleep;
		int n;
		pulse(1);
		wait_lvl(5, 1'b0, n);
		`CHK(power_mode, 4'h4, "sleep entry")
		repeat (20) @(negedge clk_sys);
		`CHK({master_clk, system_clk, periph_clk}, 10'h000, "sleep clocks")
		@(posedge clk_sys);
		wake_req <= 1'b1;
		repeat (10) @(negedge clk_sys);
		`CHK(power_mode, 4'h4, "sleep kept")
		@(posedge clk_sys);
		wake_req <= 1'b0;
		ext_irq <= 1'b1;
		wait_lvl(5, 1'b1, n);
		`CHK(n < 10, 1'b1, "irq wake")
		@(posedge clk_sys);
		ext_irq <= 1'b0;
		rtc_wake_en <= 1'b1;
		repeat (6) @(posedge clk_sys);
		pulse(1);
		wait_lvl(5, 1'b0, n);
		wait_lvl(5, 1'b1, n);
		`CHK(n < 56, 1'b1, "rtc wake")
		period(7, n);
		`CHK(n, 50, "rtc period")
		@(posedge clk_sys);
		rtc_wake_en <= 1'b0;
	endtask

	task t_owd;
		int n;
		@(posedge clk_sys);
		pll_factor <= 4'h3;
		osc_run <= 1'b0;
		wait_lvl(4, 1'b1, n);
		`CHK(n inside {[12:34]}, 1'b1, "watchdog delay")
		wait_lvl(6, 1'b1, n);
		`CHK(osc_fail, 1'b1, "fail flag")
		period(0, n);
		`CHK(n, 8, "emergency period")
		@(posedge clk_sys);
		osc_run <= 1'b1;
		repeat (40) @(posedge clk_sys);
		owd_fail_clr <= 1'b1;
		@(posedge clk_sys);
		owd_fail_clr <= 1'b0;
		repeat (3) @(negedge clk_sys);
		`CHK(osc_fail, 1'b0, "fail cleared")
		`CHK(irq_seen, 1, "one irq")
	endtask

	task t_pll_off;
		@(posedge clk_sys);
		pll_on <= 1'b0;
		osc_run <= 1'b0;
		repeat (80) @(negedge clk_sys);
		`CHK(osc_watchdog_on, 1'b0, "watchdog off")
		`CHK(osc_fail, 1'b0, "no fail")
		`CHK(irq_seen, 1, "no irq")
		@(posedge clk_sys);
		osc_run <= 1'b1;
		repeat (30) @(posedge clk_sys);
		pll_on <= 1'b1;
	endtask

	task t_strap;
		int b;
		do_reset(1'b0, 1'b0);
		b = irq_seen;
		osc_run <= 1'b0;
		repeat (80) @(negedge clk_sys);
		`CHK(osc_watchdog_on, 1'b0, "strap off")
		`CHK(irq_seen, b, "strap no irq")
		@(posedge clk_sys);
		osc_run <= 1'b1;
		do_reset(1'b1, 1'b0);
		@(negedge clk_sys);
		`CHK(osc_watchdog_on, 1'b1, "strap needs ea low")
	endtask

	task t_pdown;
		int n;
		pulse(2);
		repeat (8) @(negedge clk_sys);
		`CHK(power_mode, 4'h1, "pdown refused")
		@(posedge clk_sys);
		nmi_n <= 1'b0;
		repeat (6) @(posedge clk_sys);
		pulse(2);
		wait_lvl(5, 1'b0, n);
		`CHK(power_mode, 4'h8, "pdown entry")
		@(posedge clk_sys);
		ext_irq <= 1'b1;
		repeat (40) @(negedge clk_sys);
		`CHK(power_mode, 4'h8, "pdown held")
		`CHK(master_clk, 1'b0, "pdown clock")
	endtask

	initial begin
		do_reset(1'b1, 1'b1);
		t_clocks();
		t_periph();
		t_idle();
		t_sleep();
		t_owd();
		t_pll_off();
		t_strap();
		t_pdown();
		complete_run();
	end
endmodule

bind cgpm_clock_power cgpm_clock_power_assertions i_chk (.clk_sys, .arst_n, .pll_on,
	.instr_sleep, .enter_deep_powerdown, .master_clk, .can_clk, .cpu_clk, .system_clk,
	.osc_watchdog_irq, .osc_fail, .osc_watchdog_on, .power_mode);
